// >>> hdl/twp_pkg.sv
package twp_pkg;
  localparam logic [7:0] KEY_ADDR        = 8'hc7;
  localparam logic [7:0] KEY_FIRST       = 8'haa;
  localparam logic [7:0] KEY_SECOND      = 8'h55;
  localparam int         CLK_PER_MCYCLE  = 4;
  localparam int         ARM_MCYCLES     = 3;
  localparam int         WINDOW_MCYCLES  = 3;
  localparam logic [1:0] PHASE_LAST      = 2'h3;
  localparam logic [1:0] MC_CNT_ZERO     = 2'h0;
  localparam logic [1:0] ARM_CNT_INIT    = 2'h3;
  localparam logic [1:0] WIN_CNT_INIT    = 2'h3;
  localparam logic [7:0] PROT_RESET      = 8'h00;

  typedef enum logic [2:0] {
    TWP_IDLE   = 3'b001,
    TWP_ARMED  = 3'b010,
    TWP_OPEN   = 3'b100
  } twp_state_t;
endpackage

// >>> hdl/timed_write_protection.sv
`timescale 1ns/1ns
module timed_write_protection
  import twp_pkg::*;
#(
  parameter int PROT_WIDTH = 8
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  sfrWrEn,
  input  wire logic [7:0]            sfrAddr,
  input  wire logic [7:0]            sfrWrData,
  input  wire logic                  protWrEn,
  input  wire logic [PROT_WIDTH-1:0] protWrMask,
  input  wire logic [PROT_WIDTH-1:0] protWrData,
  output logic      [PROT_WIDTH-1:0] protBits,
  output logic                       windowOpen,
  output logic                       armed
);

  // Machine cycle phase
  logic [1:0]            phase_reg;
  logic [1:0]            phase_next;
  logic                  mcEnd;

  // Key sequencer
  twp_state_t            state_reg;
  twp_state_t            state_next;
  logic [1:0]            armCnt_reg;
  logic [1:0]            armCnt_next;
  logic [1:0]            winCnt_reg;
  logic [1:0]            winCnt_next;

  // Status outputs
  logic                  open_reg;
  logic                  open_next;
  logic                  armed_reg;
  logic                  armed_next;

  // Protected bits
  logic [PROT_WIDTH-1:0] prot_reg;
  logic [PROT_WIDTH-1:0] prot_next;
  logic                  protTake;

  // Key decode
  logic                  keyWr;
  logic                  keyFirst;
  logic                  keySecond;
  logic                  keyOther;
  logic                  armLast;
  logic                  winLast;

  // Matches a write of one key value to the key register
  function automatic logic keyMatch(
    input logic       wrEn,
    input logic [7:0] addr,
    input logic [7:0] data,
    input logic [7:0] value
  );
    keyMatch = wrEn && (addr == KEY_ADDR) && (data == value);
  endfunction

  assign keyWr     = sfrWrEn && (sfrAddr == KEY_ADDR);
  assign keyFirst  = keyMatch(sfrWrEn, sfrAddr, sfrWrData, KEY_FIRST);
  assign keySecond = keyMatch(sfrWrEn, sfrAddr, sfrWrData, KEY_SECOND);
  assign keyOther  = keyWr && !keyFirst && !keySecond;

  // four clocks per machine cycle
  // Free-running, so a duration ends on a boundary and may be up to a cycle short
  always_comb begin
    phase_next = phase_reg + 2'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase_reg <= MC_CNT_ZERO;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign mcEnd = (phase_reg == PHASE_LAST);

  assign armLast = mcEnd && (armCnt_reg == 2'h1);
  assign winLast = mcEnd && (winCnt_reg == 2'h1);

  always_comb begin
    armCnt_next = armCnt_reg;
    if ((state_reg == TWP_IDLE) && keyFirst) begin
      armCnt_next = ARM_CNT_INIT;
    end else if (state_reg == TWP_ARMED) begin
      if (keyFirst) begin
        armCnt_next = ARM_CNT_INIT;
      end else if (keyWr) begin
        armCnt_next = MC_CNT_ZERO;
      end else if (mcEnd) begin
        armCnt_next = armCnt_reg - 2'h1;
      end
    end else begin
      armCnt_next = MC_CNT_ZERO;
    end
  end

  always_comb begin
    winCnt_next = winCnt_reg;
    if ((state_reg == TWP_ARMED) && keySecond) begin
      winCnt_next = WIN_CNT_INIT;
    end else if (state_reg == TWP_OPEN) begin
      if (mcEnd) begin
        winCnt_next = winCnt_reg - 2'h1;
      end
    end else begin
      winCnt_next = MC_CNT_ZERO;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TWP_IDLE: begin
        if (keyFirst) begin
          state_next = TWP_ARMED;
        end
      end
      TWP_ARMED: begin
        if (keySecond) begin
          state_next = TWP_OPEN;
        end else if (keyFirst) begin
          state_next = TWP_ARMED;
        end else if (keyOther) begin
          // A stray key value relocks rather than waiting out the period
          state_next = TWP_IDLE;
        end else if (armLast) begin
          state_next = TWP_IDLE;
        end
      end
      TWP_OPEN: begin
        // window self-closes
        // Key writes are ignored here, so the window cannot be stretched
        if (winLast) begin
          state_next = TWP_IDLE;
        end
      end
      default: begin
        state_next = TWP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg  <= TWP_IDLE;
      armCnt_reg <= MC_CNT_ZERO;
      winCnt_reg <= MC_CNT_ZERO;
    end else begin
      state_reg  <= state_next;
      armCnt_reg <= armCnt_next;
      winCnt_reg <= winCnt_next;
    end
  end

  // Status flags track the registered state exactly
  always_comb begin
    open_next  = (state_next == TWP_OPEN);
    armed_next = (state_next == TWP_ARMED);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      open_reg  <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      open_reg  <= open_next;
      armed_reg <= armed_next;
    end
  end

  assign protTake = protWrEn && (state_reg == TWP_OPEN);

  for (genvar b = 0; b < PROT_WIDTH; b++) begin : g_prot
    assign prot_next[b] = (protTake && protWrMask[b]) ? protWrData[b] : prot_reg[b];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prot_reg <= PROT_WIDTH'(PROT_RESET);
    end else begin
      prot_reg <= prot_next;
    end
  end

  assign protBits   = prot_reg;
  assign windowOpen = open_reg;
  assign armed      = armed_reg;

endmodule // timed_write_protection

// >>> test/twp_asserts.sv
`timescale 1ns/1ns
module twp_asserts import twp_pkg::*; #(parameter int PROT_WIDTH = 8) (
  input wire logic                  clk_sys, rst_b, sfrWrEn, protWrEn, windowOpen, armed,
  input wire logic [7:0]            sfrAddr, sfrWrData,
  input wire logic [PROT_WIDTH-1:0] protWrMask, protWrData, protBits
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence keyW(v); sfrWrEn && sfrAddr == KEY_ADDR && sfrWrData == v; endsequence
  a_arm_first: assert property (keyW(KEY_FIRST) ##0 !windowOpen |=> armed) else $error("no arm");
  a_open_second: assert property (armed ##0 keyW(KEY_SECOND) |=> windowOpen) else $error("no open");
  a_open_cause: assert property ($rose(windowOpen) |-> $past(armed)) else $error("open unarmed");
  a_win_len: assert property ($rose(windowOpen) |=> windowOpen[*8] ##[1:4] !windowOpen)
    else $error("window length");
  a_arm_expire: assert property ($rose(armed) ##0 !sfrWrEn[*8] |-> ##[2:5] !armed)
    else $error("arm stuck");
  a_prot_lock: assert property (protWrEn && !windowOpen |=> $stable(protBits)) else $error("locked write");
  a_prot_take: assert property (protWrEn && windowOpen |=> protBits ==
    ($past(protWrData) & $past(protWrMask) | $past(protBits) & ~$past(protWrMask))) else $error("write lost");
  a_reset_clr: assert property (disable iff (1'b0) !rst_b |=> !windowOpen && !armed && protBits == '0)
    else $error("reset");
endmodule // twp_asserts

// >>> test/timed_write_protection_bench.sv
`timescale 1ns/1ns
module timed_write_protection_bench import twp_pkg::*;;
  logic       clk_sys = '0, rst_b = '0, sfrWrEn = '0, protWrEn = '0, windowOpen, armed;
  logic [7:0] sfrAddr = '0, sfrWrData = '0, protWrMask = '0, protWrData = '0, protBits;
  int         n_mismatch = 0, comparisons = 0, cycles = 0;
  timed_write_protection timed_write_protection_i (.clk_sys, .rst_b, .sfrWrEn, .sfrAddr, .sfrWrData,
    .protWrEn, .protWrMask, .protWrData, .protBits, .windowOpen, .armed);
  initial forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cycles == 2000) begin
    n_mismatch++;
    tally_and_finish();
  end
  task automatic chk(logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Key write when k is set, protected write otherwise
  task automatic wr(logic k, logic [7:0] m, d);
    @(negedge clk_sys);
    {sfrWrEn, protWrEn, sfrAddr, sfrWrData, protWrMask, protWrData} = {k, !k, KEY_ADDR, d, m, d};
    @(negedge clk_sys);
    {sfrWrEn, protWrEn} = '0;
  endtask
  task automatic t_locked;
    wr(0, 8'hff, 8'h5a);
    chk(protBits, 8'h00);
  endtask
  task automatic t_unlock;
    wr(1, 8'h00, KEY_FIRST);
    wr(1, 8'h00, KEY_SECOND);
    chk(8'(windowOpen), 8'h01);
    wr(0, 8'h0f, 8'ha5);
    chk(protBits, 8'h05);
    repeat (12) @(negedge clk_sys);
    chk(8'(windowOpen), 8'h00);
    wr(0, 8'hff, 8'hff);
    chk(protBits, 8'h05);
  endtask
  task automatic t_late;
    wr(1, 8'h00, KEY_FIRST);
    chk(8'(armed), 8'h01);
    repeat (13) @(negedge clk_sys);
    chk(8'(armed), 8'h00);
    wr(1, 8'h00, KEY_SECOND);
    chk(8'(windowOpen), 8'h00);
  endtask
  task automatic t_relock;
    wr(1, 8'h00, KEY_FIRST);
    wr(1, 8'h00, 8'h12);
    chk(8'(armed), 8'h00);
    wr(1, 8'h00, KEY_FIRST);
    wr(1, 8'h00, KEY_FIRST);
    chk(8'(armed), 8'h01);
    wr(1, 8'h00, KEY_SECOND);
    wr(1, 8'h00, KEY_FIRST);
    chk(8'(windowOpen), 8'h01);
    chk(8'(armed), 8'h00);
    rst_b = '0;
    @(negedge clk_sys);
    rst_b = '1;
    chk(8'(windowOpen), 8'h00);
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    rst_b = '1;
    t_locked();
    t_unlock();
    t_late();
    rst_b = '0;
    @(negedge clk_sys);
    rst_b = '1;
    chk(protBits, 8'h00);
    t_relock();
    tally_and_finish();
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
endmodule // timed_write_protection_bench
bind timed_write_protection twp_asserts #(.PROT_WIDTH(PROT_WIDTH)) twp_asserts_i (.clk_sys, .rst_b, .sfrWrEn,
  .sfrAddr, .sfrWrData, .protWrEn, .protWrMask, .protWrData, .protBits, .windowOpen, .armed);
